// [rtl/nvs_pkg.sv]
package nvs_pkg;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_SAVE = 8'h3C;
    localparam logic [7:0] OP_RESTORE = 8'h60;
    localparam logic [7:0] OP_AUTOSAVE_ON = 8'h59;
    localparam logic [7:0] OP_AUTOSAVE_OFF = 8'h19;
    localparam int ADDR_W = 15;
    localparam logic [14:0] ADDR_MAX = 15'h7FFF;
    localparam int CLK_MHZ = 125;
    localparam int SOFTWARE_SEQUENCE_TIME_US = 100;
    localparam int SEQ_CYCLES = SOFTWARE_SEQUENCE_TIME_US * CLK_MHZ;
    localparam int SCK_DIV = 4;
    typedef enum logic [1:0] {NVS_IDLE, NVS_SAVE, NVS_RESTORE, NVS_SETTLE} nvs_busy_e;
endpackage

// [rtl/nvs_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface nvs_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_o;
    logic so_oe_n;
    logic hold_n;
    modport dev (input cs_n, input sck, input si, input hold_n, output so_o, output so_oe_n);
    modport host (output cs_n, output sck, output si, output hold_n, input so_o, input so_oe_n);
endinterface
`default_nettype wire

// [rtl/nvs_device.sv]
// Summary of operation
// - read: opcode, two address bytes, top ignored
// - read data msb first on falling sck
// - si ignored after read address
// - read address increments, wraps 7fff to 0
// - master ends single read after one byte
// - write needs latch, opcode, address, data
// - burst write increments and wraps
// - master ends single write after d0
// - write completion clears write latch
// - protected addresses increment, data dropped
// - opcode 3c starts software save
// - opcode 60 starts software restore
// - opcodes 59 and 19 toggle autosave
// - save runs whatever the autosave setting
// - special ops need latch, cleared at cs rise
// - autosave enabled by default, volatile
// - no-autosave variant: opcodes only busy
// - master pauses with hold while sck low
// - paused: si ignored, so released, state kept
// - master resumes with hold while sck low
// - latch clear: write and specials ignored
// - ready flag high during save or restore
// - no read or write while busy
`timescale 1ns/100ps
`default_nettype none
module nvs_device #(
    parameter bit HAS_AUTOSAVE = 1'b1,
    parameter int SEQ_CYCLES = nvs_pkg::SEQ_CYCLES,
    parameter logic [14:0] PROT_LO = 15'h6000,
    parameter bit PROT_EN = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    nvs_link_if.dev link,
    output logic mem_we,
    output logic [14:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic save_pulse,
    output logic restore_pulse,
    output logic busy,
    output logic autosave_en,
    output logic write_latch
);
    typedef enum logic [2:0] {PH_OP, PH_A1, PH_A2, PH_RD, PH_WR, PH_IGN, PH_SPC} nvs_ph_e;
    nvs_ph_e ph_reg;
    logic sck_reg, cs_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] sh_reg, op_reg, tx_reg;
    logic [14:0] addr_reg;
    logic so_reg;
    logic wrote_reg;
    logic wr_step_reg;
    nvs_pkg::nvs_busy_e bstate_reg;
    logic [31:0] bcnt_reg;
    wire logic active = !link.cs_n && link.hold_n;
    wire logic rise = active && link.sck && !sck_reg;
    wire logic fall = active && !link.sck && sck_reg;
    wire logic cs_rise = link.cs_n && !cs_reg;
    wire logic [7:0] byte_in = {sh_reg[6:0], link.si};
    wire logic byte_done = rise && bit_cnt_reg == 3'd7;
    // one protected window, from PROT_LO to the top of the array
    wire logic prot = PROT_EN && addr_reg >= PROT_LO;
    // busy doubles as the ready flag a status read would show
    assign busy = bstate_reg != nvs_pkg::NVS_IDLE;
    assign mem_addr = addr_reg;
    assign link.so_o = so_reg;
    // so released outside a read and while paused
    assign link.so_oe_n = !(ph_reg == PH_RD && active);
    // edges come from comparing against the previous sample
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_reg <= 1'b0;
            cs_reg <= 1'b1;
        end else begin
            sck_reg <= link.sck;
            cs_reg <= link.cs_n;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_reg <= PH_OP;
            bit_cnt_reg <= 3'd0;
            sh_reg <= 8'h00;
            op_reg <= 8'h00;
            addr_reg <= 15'h0000;
        end else if (link.cs_n) begin
            ph_reg <= PH_OP;
            bit_cnt_reg <= 3'd0;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            sh_reg <= byte_in;
            if (byte_done) begin
                unique case (ph_reg)
                    PH_OP: begin
                        // read or write while busy lands in PH_SPC, which only drops the latch
                        op_reg <= byte_in;
                        if ((byte_in == nvs_pkg::OP_READ || byte_in == nvs_pkg::OP_WRITE)
                            && !busy) begin
                            ph_reg <= (byte_in == nvs_pkg::OP_WRITE && !write_latch)
                                ? PH_IGN : PH_A1;
                        end else begin
                            ph_reg <= PH_SPC;
                        end
                    end
                    PH_A1: begin
                        addr_reg[14:8] <= byte_in[6:0];
                        ph_reg <= PH_A2;
                    end
                    PH_A2: begin
                        addr_reg[7:0] <= byte_in;
                        ph_reg <= op_reg == nvs_pkg::OP_READ ? PH_RD : PH_WR;
                    end
                    PH_RD: addr_reg <= addr_reg + 15'd1;
                    PH_WR, PH_IGN, PH_SPC: ph_reg <= ph_reg;
                endcase
            end
        end else if (wr_step_reg) begin
            // write address steps one cycle late, after the store has used it
            addr_reg <= addr_reg + 15'd1;
        end
    end
    // read byte shifts out on falling edges; data fetched from memory on the first falling edge of each byte
    // first bit of a byte comes straight from memory, the rest from tx_reg
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_reg <= 8'h00;
            so_reg <= 1'b0;
        end else if (ph_reg == PH_RD && fall) begin
            if (bit_cnt_reg == 3'd0) begin
                so_reg <= mem_rdata[7];
                tx_reg <= {mem_rdata[6:0], 1'b0};
            end else begin
                so_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            wrote_reg <= 1'b0;
            wr_step_reg <= 1'b0;
        end else begin
            mem_we <= ph_reg == PH_WR && byte_done && !prot;
            wr_step_reg <= ph_reg == PH_WR && byte_done;
            if (ph_reg == PH_WR && byte_done) begin
                mem_wdata <= byte_in;
                wrote_reg <= 1'b1;
            end else if (link.cs_n) begin
                wrote_reg <= 1'b0;
            end
        end
    end
    // mem_addr still holds the write address the cycle mem_we is high
    // unknown opcodes drop the latch too, the safer side
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_latch <= 1'b0;
        end else if (cs_rise) begin
            if (op_reg == nvs_pkg::OP_SET_WRITE_LATCH && ph_reg == PH_SPC) begin
                write_latch <= 1'b1;
            end else if (ph_reg == PH_SPC || wrote_reg) begin
                write_latch <= 1'b0;
            end
        end
    end
    // a busy device refuses a new special op rather than restart the timer
    wire logic spc_go = cs_rise && ph_reg == PH_SPC && write_latch && !busy;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            autosave_en <= HAS_AUTOSAVE;
            bstate_reg <= nvs_pkg::NVS_IDLE;
            bcnt_reg <= 32'd0;
            save_pulse <= 1'b0;
            restore_pulse <= 1'b0;
        end else begin
            save_pulse <= 1'b0;
            restore_pulse <= 1'b0;
            if (spc_go && op_reg == nvs_pkg::OP_SAVE) begin
                bstate_reg <= nvs_pkg::NVS_SAVE;
                save_pulse <= 1'b1;
                bcnt_reg <= 32'(SEQ_CYCLES);
            end else if (spc_go && op_reg == nvs_pkg::OP_RESTORE) begin
                bstate_reg <= nvs_pkg::NVS_RESTORE;
                restore_pulse <= 1'b1;
                bcnt_reg <= 32'(SEQ_CYCLES);
            end else if (spc_go && (op_reg == nvs_pkg::OP_AUTOSAVE_ON
                || op_reg == nvs_pkg::OP_AUTOSAVE_OFF)) begin
                // without autosave the opcodes change nothing but still hold busy
                if (HAS_AUTOSAVE) begin
                    autosave_en <= op_reg == nvs_pkg::OP_AUTOSAVE_ON;
                end
                bstate_reg <= nvs_pkg::NVS_SETTLE;
                bcnt_reg <= 32'(SEQ_CYCLES);
            end else if (busy) begin
                if (bcnt_reg <= 32'd1) begin
                    bstate_reg <= nvs_pkg::NVS_IDLE;
                end
                bcnt_reg <= bcnt_reg - 32'd1;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/nvs_host.sv]
`timescale 1ns/100ps
`default_nettype none
module nvs_host #(
    parameter int SCK_DIV = nvs_pkg::SCK_DIV
) (
    input wire logic clk,
    input wire logic arst_n,
    nvs_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_op,
    input wire logic [14:0] cmd_addr,
    input wire logic [3:0] cmd_len,
    input wire logic [7:0] wr_data,
    output logic wr_take,
    input wire logic pause,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data
);
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END} nvs_hst_e;
    nvs_hst_e st_reg;
    logic [7:0] div_reg;
    logic [7:0] txb_reg, rxb_reg;
    logic [2:0] bit_reg;
    logic [4:0] byte_reg, nbytes_reg;
    logic [7:0] op_reg;
    logic [14:0] addr_reg;
    logic sck_reg, hold_reg;
    logic [7:0] buf_reg [2];
    logic [1:0] cnt_reg;
    logic wp_reg, rp_reg;
    logic push;
    wire logic tick = div_reg == 8'(SCK_DIV - 1);
    wire logic is_rd = op_reg == nvs_pkg::OP_READ;
    wire logic last_bit = bit_reg == 3'd7;
    // room must exist before a read byte starts, so a stalled receiver stops sck
    wire logic room = cnt_reg == 2'd0 || (cnt_reg == 2'd1 && !push);
    wire logic stall = is_rd && byte_reg >= 5'd3 && !room && bit_reg == 3'd0 && !sck_reg;
    // a pause may not start on the edge that raises sck, or sck would freeze high
    wire logic hold_ok = !sck_reg && !(st_reg == H_SHIFT && tick && !stall && hold_reg);
    assign cmd_ready = st_reg == H_IDLE;
    assign link.cs_n = st_reg == H_IDLE;
    assign link.sck = sck_reg;
    assign link.si = txb_reg[7];
    assign link.hold_n = hold_reg;
    assign rd_valid = cnt_reg != 2'd0;
    assign rd_data = buf_reg[rp_reg];
    assign push = st_reg == H_SHIFT && tick && sck_reg && last_bit && is_rd && byte_reg >= 5'd3;
    assign wr_take = st_reg == H_SHIFT && tick && sck_reg && last_bit
        && op_reg == nvs_pkg::OP_WRITE && byte_reg >= 5'd2 && byte_reg + 5'd1 < nbytes_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= 1'b1;
        end else if (hold_ok) begin
            hold_reg <= !pause;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= H_IDLE;
            div_reg <= 8'd0;
            sck_reg <= 1'b0;
            txb_reg <= 8'h00;
            rxb_reg <= 8'h00;
            bit_reg <= 3'd0;
            byte_reg <= 5'd0;
            nbytes_reg <= 5'd0;
            op_reg <= 8'h00;
            addr_reg <= 15'h0000;
        end else begin
            unique case (st_reg)
                H_IDLE: begin
                    if (cmd_valid) begin
                        op_reg <= cmd_op;
                        addr_reg <= cmd_addr;
                        txb_reg <= cmd_op;
                        bit_reg <= 3'd0;
                        byte_reg <= 5'd0;
                        div_reg <= 8'd0;
                        nbytes_reg <= (cmd_op == nvs_pkg::OP_READ || cmd_op == nvs_pkg::OP_WRITE)
                            ? 5'd3 + {1'b0, cmd_len} : 5'd1;
                        st_reg <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (!stall && hold_reg) begin
                        div_reg <= tick ? 8'd0 : div_reg + 8'd1;
                    end
                    if (tick && !stall && hold_reg) begin
                        sck_reg <= !sck_reg;
                        if (!sck_reg) begin
                            // a released so line reads as pulled high
                            rxb_reg <= {rxb_reg[6:0], link.so_o | link.so_oe_n};
                        end else begin
                            bit_reg <= bit_reg + 3'd1;
                            txb_reg <= {txb_reg[6:0], 1'b0};
                            if (last_bit) begin
                                byte_reg <= byte_reg + 5'd1;
                                unique case (byte_reg)
                                    5'd0: txb_reg <= {1'b0, addr_reg[14:8]};
                                    5'd1: txb_reg <= addr_reg[7:0];
                                    default: txb_reg <= wr_data;
                                endcase
                                if (byte_reg + 5'd1 == nbytes_reg) begin
                                    st_reg <= H_END;
                                end
                            end
                        end
                    end
                end
                H_END: st_reg <= H_IDLE;
                default: st_reg <= H_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 2'd0;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            buf_reg[0] <= 8'h00;
            buf_reg[1] <= 8'h00;
        end else begin
            if (push) begin
                buf_reg[wp_reg] <= rxb_reg;
                wp_reg <= !wp_reg;
            end
            if (rd_valid && rd_ready) begin
                rp_reg <= !rp_reg;
            end
            cnt_reg <= cnt_reg + 2'(push) - 2'(rd_valid && rd_ready);
        end
    end
endmodule
`default_nettype wire

// [dv/nvs_link_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module nvs_link_sva #(
    parameter int SEQ_CYCLES = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_o,
    input wire logic so_oe_n,
    input wire logic hold_n,
    input wire logic busy,
    input wire logic write_latch,
    input wire logic mem_we
);
    int busy_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // length of the current busy stretch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 1 : 0;
        end
    end
    idle_so_off_a: assert property (cs_n && $past(cs_n) |-> so_oe_n)
        else $error("so driven while deselected");
    so_fall_edge_a: assert property (!cs_n && !so_oe_n && $past(!so_oe_n) && $changed(so_o)
        |-> !sck)
        else $error("so changed while sck high");
    hold_so_off_a: assert property ((!hold_n && !cs_n)[*4] |-> so_oe_n)
        else $error("so driven while paused");
    busy_start_a: assert property ($rose(busy) |-> $past(cs_n))
        else $error("busy began inside a frame");
    busy_len_a: assert property ($fell(busy) |-> busy_cnt >= SEQ_CYCLES
        && busy_cnt <= SEQ_CYCLES + 8)
        else $error("busy stretch of wrong length");
    busy_no_we_a: assert property (busy |-> !mem_we)
        else $error("memory written while busy");
    busy_so_off_a: assert property (busy && $past(busy) |-> so_oe_n)
        else $error("so driven while busy");
    latch_fall_a: assert property ($fell(write_latch) |-> cs_n || $past(cs_n)
        || $past(cs_n, 2))
        else $error("write latch cleared inside a frame");
    we_needs_latch_a: assert property (mem_we |-> write_latch)
        else $error("memory written without latch");
    hold_edge_a: assert property ($changed(hold_n) |-> !sck)
        else $error("hold changed while sck high");
    si_stable_a: assert property (!cs_n && sck |-> $stable(si))
        else $error("si changed while sck high");
endmodule
`default_nettype wire

// [dv/spi_nvram_command_slave_test.sv]
`timescale 1ns/100ps
`default_nettype none
module spi_nvram_command_slave_test;
    logic clk, arst_n, cmd_valid, cmd_ready, wr_take, pause, rd_valid, rd_ready;
    logic mem_we, save_pulse, restore_pulse, busy, autosave_en, write_latch;
    logic [7:0] cmd_op, wr_data, rd_data, mem_wdata, mem_rdata;
    logic [14:0] cmd_addr, mem_addr;
    logic [3:0] cmd_len;
    logic [7:0] mem [0:32767];
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    logic [7:0] ops [5] = '{8'h3C, 8'h60, 8'h19, 8'h59, 8'h3C};
    int bad_count, checked, saves, restores;
    nvs_link_if link();
    nvs_device #(.SEQ_CYCLES(100), .PROT_EN(1'b1), .PROT_LO(15'h6000)) u_nvs_device (
        .clk(clk), .arst_n(arst_n), .link(link), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .save_pulse(save_pulse),
        .restore_pulse(restore_pulse), .busy(busy), .autosave_en(autosave_en),
        .write_latch(write_latch));
    nvs_host u_nvs_host (.clk(clk), .arst_n(arst_n), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .wr_data(wr_data), .wr_take(wr_take), .pause(pause), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));
    nvs_link_sva #(.SEQ_CYCLES(100)) u_nvs_link_sva (.clk(clk), .arst_n(arst_n),
        .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so_o(link.so_o),
        .so_oe_n(link.so_oe_n), .hold_n(link.hold_n), .busy(busy),
        .write_latch(write_latch), .mem_we(mem_we));
    // combinational memory, as the device expects
    assign mem_rdata = mem[mem_addr];
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (rd_valid && rd_ready) rq.push_back(rd_data);
        if (save_pulse) saves++;
        if (restore_pulse) restores++;
        if (wr_take) wr_data <= (wq.size() > 0) ? wq.pop_front() : 8'h00;
    end
    function automatic logic [7:0] iv(input int a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic send(input logic [7:0] op, input logic [14:0] a, input logic [3:0] n);
        int k;
        k = 0;
        @(posedge clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= n;
        if (wq.size() > 0) wr_data <= wq.pop_front();
        cmd_valid <= 1'b1;
        do @(negedge clk); while (!cmd_ready);
        @(posedge clk);
        cmd_valid <= 1'b0;
        // bounded waits: frame start, then frame end
        while (link.cs_n && k < 50) begin
            @(negedge clk);
            k++;
        end
        while ((!link.cs_n || !cmd_ready) && k < 20000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 20000) chk_bit(1'b1, 1'b0);
        repeat (4) @(posedge clk);
    endtask
    task automatic latch_on();
        send(nvs_pkg::OP_SET_WRITE_LATCH, 15'h0000, 4'h0);
        chk_bit(write_latch, 1'b1);
    endtask
    task automatic done_test(input string s);
        $display("test %s done, checked=%0d bad=%0d", s, checked, bad_count);
    endtask
    task automatic stop_test();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        {cmd_valid, cmd_op, cmd_addr, cmd_len, wr_data, pause} = '0;
        rd_ready = 1'b1;
        {bad_count, checked, saves, restores} = '0;
        for (int i = 0; i < 32768; i++) mem[i] = iv(i);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk_bit(autosave_en, 1'b1);
        chk_bit(write_latch, 1'b0);
        latch_on();
        wq = '{8'h11, 8'h22, 8'h33, 8'h44};
        send(nvs_pkg::OP_WRITE, 15'h7FFE, 4'h4);
        chk_byte(mem[32766], iv(32766));
        chk_byte(mem[0], 8'h33);
        chk_byte(mem[1], 8'h44);
        chk_bit(write_latch, 1'b0);
        wq = '{8'hEE};
        send(nvs_pkg::OP_WRITE, 15'h0010, 4'h1);
        chk_byte(mem[16], iv(16));
        done_test("write");
        latch_on();
        wq = '{8'hC3};
        send(nvs_pkg::OP_WRITE, 15'h0100, 4'h1);
        rq.delete();
        fork
            send(nvs_pkg::OP_READ, 15'h00FF, 4'h3);
            begin
                repeat (250) @(posedge clk);
                pause <= 1'b1;
                repeat (60) @(posedge clk);
                pause <= 1'b0;
            end
        join
        chk_byte(8'(rq.size()), 8'h03);
        chk_byte(rq[0], iv(255));
        chk_byte(rq[1], 8'hC3);
        chk_byte(rq[2], iv(257));
        rq.delete();
        rd_ready <= 1'b0;
        // stalled reader must not lose a byte
        fork
            send(nvs_pkg::OP_READ, 15'h7FFF, 4'h3);
            begin
                repeat (350) @(posedge clk);
                rd_ready <= 1'b1;
            end
        join
        chk_byte(8'(rq.size()), 8'h03);
        chk_byte(rq[0], iv(32767));
        chk_byte(rq[1], 8'h33);
        chk_byte(rq[2], 8'h44);
        done_test("read");
        for (int i = 0; i < 5; i++) begin
            latch_on();
            send(ops[i], 15'h0000, 4'h0);
            chk_bit(write_latch, 1'b0);
            chk_bit(busy, 1'b1);
            repeat (120) @(posedge clk);
            chk_byte(8'(saves), (i == 4) ? 8'h02 : 8'h01);
            chk_byte(8'(restores), (i == 0) ? 8'h00 : 8'h01);
            chk_bit(autosave_en, i != 2);
        end
        send(nvs_pkg::OP_SAVE, 15'h0000, 4'h0);
        chk_bit(busy, 1'b0);
        latch_on();
        send(nvs_pkg::OP_SAVE, 15'h0000, 4'h0);
        rq.delete();
        send(nvs_pkg::OP_READ, 15'h0000, 4'h1);
        repeat (120) @(posedge clk);
        chk_byte(8'(rq.size()), 8'h01);
        chk_byte(rq[0], 8'hFF);
        chk_byte(8'(saves), 8'h03);
        done_test("special");
        stop_test();
    end
    initial begin
        #400_000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
